// ---- mii_phy_port.sv ----
// one mii port toward an external phy: nibble rx/tx, tx delay, management pins
// assumes the phy shares the 25 MHz reference; phy pins and the link, offset and shift inputs are resynchronised here
//
// Behaviour
// R1 - the phy raises its link pin only while a full-duplex 100 Mbit/s link is up.
// R2 - a static input selects whether the phy address offset is applied.
// R3 - receive nibbles, data valid and error are taken with the phy receive clock.
// R4 - transmit nibbles go out qualified by the transmit enable output.
// R5 - the management clock is driven to both levels and rests high when idle.
// R6 - the phy address is the port number or address register plus the offset.
// R7 - the offset of 16 inverts the top bit of the 5-bit phy address.
// R8 - without either scheme the phys sit at 0 to 3 and the offset input stays 0.
// R9 - any non-zero configured or actual offset disables enhanced link detection.
// R10 - the phy transmit clock is unused and transmit data skips any output fifo.
// R11 - link state comes only from the link pin, never from the data path.
// R12 - each phy is clocked from the reference outputs or the shared oscillator.
// R13 - transmit timing derives from the shared reference clock.
// R14 - transmit enable and data are delayed by one of four steps.
// R15 - the integrator picks the delay so transmit changes mid-window.
// R16 - the low nibble of a byte goes first, and rx assembles in the same order.
`default_nettype none

module mii_phy_port
    import mii_port_pkg::*;
#(
    parameter int MGMT_HALF = mii_port_pkg::MGMT_HALF_CYC,
    parameter int STEP_CYC  = mii_port_pkg::TX_SHIFT_STEP_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    input  wire logic        link_mii_i,
    input  wire logic        link_input_polarity_cfg_i,
    input  wire logic        phy_addr_offset_cfg_i,
    input  wire logic        phy_actual_offset_nz_i,
    input  wire logic        enh_link_req_i,
    input  wire logic [1:0]  tx_shift_i,
    input  wire logic [1:0]  port_num_i,
    input  wire logic        use_addr_reg_i,
    input  wire logic [4:0]  phy_addr_reg_i,
    input  wire logic        rx_clk_i,
    input  wire logic        rx_dv_i,
    input  wire logic [3:0]  rxd_i,
    input  wire logic        rx_err_i,
    output var  logic        tx_enable_out_o,
    output var  logic [3:0]  txd_o,
    input  wire logic [7:0]  tx_data_i,
    input  wire logic        tx_valid_i,
    input  wire logic        tx_hold_i,
    output var  logic        tx_ready_o,
    output var  logic [7:0]  rx_byte_o,
    output var  logic        rx_byte_valid_o,
    output var  logic        rx_byte_err_o,
    output var  logic        rx_end_o,
    output var  logic        rx_odd_o,
    output var  logic        link_up_o,
    output var  logic        enh_link_en_o,
    output var  logic [4:0]  phy_addr_o,
    input  wire logic        mgmt_start_i,
    input  wire logic        mgmt_write_i,
    input  wire logic [4:0]  mgmt_reg_i,
    input  wire logic [15:0] mgmt_wdata_i,
    output var  logic        mgmt_busy_o,
    output var  logic        mgmt_done_o,
    output var  logic [15:0] mgmt_rdata_o,
    output var  logic        mgmt_clock_out_o,
    output var  logic        mgmt_data_io_o,
    output var  logic        mgmt_data_io_oe_o,
    input  wire logic        mgmt_data_io_i
);
    import mii_port_pkg::*;

    localparam int NS    = 14;
    localparam int PIPE  = (TX_SHIFT_STEPS - 1) * STEP_CYC;
    localparam int DIV_W = $clog2(MGMT_HALF + 1);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    // ---- pin synchronisers
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic          rx_clk_d;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            s1       <= '0;
            s2       <= '0;
            rx_clk_d <= 1'b0;
        end else begin
            s1       <= {link_mii_i, link_input_polarity_cfg_i, phy_addr_offset_cfg_i,
                         phy_actual_offset_nz_i, tx_shift_i, rx_clk_i, rx_dv_i, rxd_i,
                         rx_err_i, mgmt_data_io_i};
            s2       <= s1;
            rx_clk_d <= s2[7];
        end
    end

    logic       link_s, pol_s, off_cfg_s, act_nz_s, rx_clk_s, rx_dv_s, rx_err_s, mdio_s;
    logic [1:0] shift_s;
    logic [3:0] rxd_s;
    logic       rx_clk_rise;
    assign {link_s, pol_s, off_cfg_s, act_nz_s, shift_s, rx_clk_s, rx_dv_s, rxd_s,
            rx_err_s, mdio_s} = s2;
    assign rx_clk_rise = rx_clk_s && !rx_clk_d;

    // ---- link, address and enhanced link detection
    logic [4:0] next_phy_addr;
    logic [4:0] addr_base;
    always_comb begin
        addr_base     = use_addr_reg_i ? phy_addr_reg_i : {3'h0, port_num_i};
        next_phy_addr = addr_base ^ (off_cfg_s ? PHY_ADDR_OFFSET_MASK : 5'h00); // R2 R6 R7
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            phy_addr_o    <= 5'h00;
            link_up_o     <= 1'b0;
            enh_link_en_o <= 1'b0;
        end else begin
            phy_addr_o    <= next_phy_addr;
            // polarity high means the link pin is active low
            link_up_o     <= link_s ^ pol_s; // R11
            enh_link_en_o <= enh_link_req_i && !off_cfg_s && !act_nz_s; // R9
        end
    end

    // ---- receive nibble assembly, sampled on rising receive clock edges
    logic [3:0] rx_lo, next_rx_lo;
    logic       rx_half, next_rx_half, rx_err_acc, next_rx_err_acc, rx_dv_d, next_rx_dv_d;
    logic [7:0] next_rx_byte;
    logic       next_rx_byte_valid, next_rx_byte_err, next_rx_end, next_rx_odd;

    always_comb begin
        next_rx_lo         = rx_lo;
        next_rx_half       = rx_half;
        next_rx_err_acc    = rx_err_acc;
        next_rx_dv_d       = rx_dv_d;
        next_rx_byte       = rx_byte_o;
        next_rx_byte_valid = 1'b0;
        next_rx_byte_err   = rx_byte_err_o;
        next_rx_end        = 1'b0;
        next_rx_odd        = rx_odd_o;
        if (rx_clk_rise) begin // R3
            next_rx_dv_d = rx_dv_s;
            if (rx_dv_s && !rx_half) begin
                next_rx_lo      = rxd_s;
                next_rx_half    = 1'b1;
                next_rx_err_acc = rx_err_s;
            end else if (rx_dv_s) begin
                next_rx_byte       = {rxd_s, rx_lo}; // R16
                next_rx_byte_valid = 1'b1;
                next_rx_byte_err   = rx_err_acc || rx_err_s;
                next_rx_half       = 1'b0;
            end else if (rx_dv_d) begin
                // a dangling nibble at frame end is flagged, not delivered
                next_rx_end  = 1'b1;
                next_rx_odd  = rx_half;
                next_rx_half = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rx_lo           <= 4'h0;
            rx_half         <= 1'b0;
            rx_err_acc      <= 1'b0;
            rx_dv_d         <= 1'b0;
            rx_byte_o       <= 8'h00;
            rx_byte_valid_o <= 1'b0;
            rx_byte_err_o   <= 1'b0;
            rx_end_o        <= 1'b0;
            rx_odd_o        <= 1'b0;
        end else begin
            rx_lo           <= next_rx_lo;
            rx_half         <= next_rx_half;
            rx_err_acc      <= next_rx_err_acc;
            rx_dv_d         <= next_rx_dv_d;
            rx_byte_o       <= next_rx_byte;
            rx_byte_valid_o <= next_rx_byte_valid;
            rx_byte_err_o   <= next_rx_byte_err;
            rx_end_o        <= next_rx_end;
            rx_odd_o        <= next_rx_odd;
        end
    end

    // ---- transmit: user fifo, then straight nibble serialiser
    logic [7:0] fifo_data;
    logic       fifo_valid, drain_ready, pop;
    tx_fifo #(
        .WIDTH(TX_FIFO_WIDTH),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .in_data_i  (tx_data_i),
        .in_valid_i (tx_valid_i),
        .in_ready_o (tx_ready_o),
        .out_data_o (fifo_data),
        .out_valid_o(fifo_valid),
        .out_ready_i(drain_ready)
    );

    tx_state_t  tx_st, next_tx_st;
    logic [7:0] tx_byte, next_tx_byte;
    logic [3:0] tx_nib, next_tx_nib;
    logic       tx_en_raw, next_tx_en;

    // the TX_LO cycle never pops, so the fifo drains at most one byte every two cycles
    assign drain_ready = !tx_hold_i && (tx_st != TX_LO);
    assign pop         = drain_ready && fifo_valid;

    always_comb begin
        next_tx_st   = tx_st;
        next_tx_byte = tx_byte;
        next_tx_nib  = tx_nib;
        next_tx_en   = tx_en_raw;
        case (tx_st)
            TX_LO: begin
                next_tx_nib = tx_byte[7:4]; // R16
                next_tx_en  = 1'b1;
                next_tx_st  = TX_HI;
            end
            default: begin
                if (pop) begin
                    next_tx_byte = fifo_data;
                    next_tx_nib  = fifo_data[3:0]; // R4 R16
                    next_tx_en   = 1'b1;
                    next_tx_st   = TX_LO;
                end else begin
                    next_tx_nib = 4'h0;
                    next_tx_en  = 1'b0;
                    next_tx_st  = TX_IDLE;
                end
            end
        endcase
    end

    // output delay line on the system clock; no phy transmit clock input exists
    logic [4:0] tx_pipe [PIPE];
    logic [4:0] next_tap;
    always_comb begin
        next_tap = {tx_en_raw, tx_nib};
        if (shift_s != 2'h0) begin
            next_tap = tx_pipe[int'(shift_s) * STEP_CYC - 1]; // R14
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            tx_st           <= TX_IDLE;
            tx_byte         <= 8'h00;
            tx_nib          <= 4'h0;
            tx_en_raw       <= 1'b0;
            tx_enable_out_o <= 1'b0;
            txd_o           <= 4'h0;
            for (int i = 0; i < PIPE; i++) begin
                tx_pipe[i] <= 5'h00;
            end
        end else begin
            tx_st      <= next_tx_st;
            tx_byte    <= next_tx_byte;
            tx_nib     <= next_tx_nib;
            tx_en_raw  <= next_tx_en;
            tx_pipe[0] <= {tx_en_raw, tx_nib};
            for (int i = 1; i < PIPE; i++) begin
                tx_pipe[i] <= tx_pipe[i-1];
            end
            {tx_enable_out_o, txd_o} <= next_tap; // R10 R13
        end
    end

    // ---- management serial engine
    logic             m_read, next_m_read, next_m_busy, next_m_done, next_m_clk;
    logic             next_m_do, next_m_oe;
    logic [DIV_W-1:0] m_div, next_m_div;
    logic [5:0]       m_bit, next_m_bit;
    logic [63:0]      m_sreg, next_m_sreg, frame;
    logic [15:0]      next_m_rdata;

    always_comb begin
        frame = mgmt_write_i
              ? {{32{1'b1}}, MGMT_SOF, MGMT_OP_WRITE, phy_addr_o, mgmt_reg_i,
                 MGMT_TA_WRITE, mgmt_wdata_i}
              : {{32{1'b1}}, MGMT_SOF, MGMT_OP_READ, phy_addr_o, mgmt_reg_i,
                 2'h0, 16'h0000};
        next_m_busy  = mgmt_busy_o;
        next_m_done  = 1'b0;
        next_m_clk   = mgmt_clock_out_o;
        next_m_do    = mgmt_data_io_o;
        next_m_oe    = mgmt_data_io_oe_o;
        next_m_read  = m_read;
        next_m_div   = m_div;
        next_m_bit   = m_bit;
        next_m_sreg  = m_sreg;
        next_m_rdata = mgmt_rdata_o;
        if (!mgmt_busy_o) begin
            next_m_clk = 1'b1; // R5
            next_m_oe  = 1'b0;
            if (mgmt_start_i) begin
                next_m_busy = 1'b1;
                next_m_sreg = frame;
                next_m_read = !mgmt_write_i;
                next_m_bit  = 6'h00;
                next_m_div  = '0;
                next_m_clk  = 1'b0;
                next_m_do   = frame[63];
                next_m_oe   = 1'b1;
            end
        end else if (m_div != DIV_W'(MGMT_HALF - 1)) begin
            next_m_div = DIV_W'(m_div + 1'b1);
        end else begin
            next_m_div = '0;
            if (!mgmt_clock_out_o) begin
                next_m_clk = 1'b1;
                if (m_read && m_bit >= MGMT_DATA_BIT) begin
                    next_m_rdata = {mgmt_rdata_o[14:0], mdio_s};
                end
            end else if (m_bit == MGMT_LAST_BIT) begin
                next_m_busy = 1'b0;
                next_m_done = 1'b1;
                next_m_oe   = 1'b0;
            end else begin
                next_m_bit  = 6'(m_bit + 1'b1);
                next_m_sreg = {m_sreg[62:0], 1'b0};
                next_m_clk  = 1'b0;
                next_m_do   = m_sreg[62];
                // phy owns the data line from turnaround onward in a read
                next_m_oe   = !(m_read && next_m_bit >= MGMT_TA_BIT);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            mgmt_busy_o       <= 1'b0;
            mgmt_done_o       <= 1'b0;
            mgmt_clock_out_o  <= 1'b1;
            mgmt_data_io_o    <= 1'b1;
            mgmt_data_io_oe_o <= 1'b0;
            mgmt_rdata_o      <= 16'h0000;
            m_read            <= 1'b0;
            m_div             <= '0;
            m_bit             <= 6'h00;
            m_sreg            <= 64'h0000000000000000;
        end else begin
            mgmt_busy_o       <= next_m_busy;
            mgmt_done_o       <= next_m_done;
            mgmt_clock_out_o  <= next_m_clk;
            mgmt_data_io_o    <= next_m_do;
            mgmt_data_io_oe_o <= next_m_oe;
            mgmt_rdata_o      <= next_m_rdata;
            m_read            <= next_m_read;
            m_div             <= next_m_div;
            m_bit             <= next_m_bit;
            m_sreg            <= next_m_sreg;
        end
    end

    // ---- checks
    sequence s_byte_split;
        (tx_st == TX_LO) ##1 (tx_st == TX_HI);
    endsequence

    AST_MCLK_IDLE_HIGH: assert property (!mgmt_busy_o |-> mgmt_clock_out_o) // R5
        else $error("management clock low while idle");
    AST_ADDR_PLAIN: assert property (!off_cfg_s |=> phy_addr_o == $past(addr_base)) // R6
        else $error("phy address differs from base without offset");
    AST_ADDR_OFFSET16: assert property (off_cfg_s |=> // R7
        phy_addr_o == {!$past(addr_base[4]), $past(addr_base[3:0])})
        else $error("offset 16 did not invert address msb");
    AST_ENH_LINK_OFF: assert property ((off_cfg_s || act_nz_s) |=> !enh_link_en_o) // R9
        else $error("enhanced link detection left on with offset");
    AST_LINK_PIN_ONLY: assert property (link_up_o == $past(link_s ^ pol_s)) // R11
        else $error("link state not taken from link pin");
    AST_RX_ORDER: assert property (rx_byte_valid_o |-> // R16
        rx_byte_o == {$past(rxd_s), $past(rx_lo)})
        else $error("received byte assembled in wrong nibble order");
    AST_TX_ORDER: assert property (s_byte_split |-> tx_nib == tx_byte[7:4] && tx_en_raw) // R16
        else $error("high nibble not sent after low nibble");
    AST_TX_SHIFT2: assert property ((shift_s == 2'h2)[*4] |-> // R14
        {tx_enable_out_o, txd_o} == {$past(tx_en_raw, 3), $past(tx_nib, 3)})
        else $error("transmit delay of two steps not applied");
    AST_TX_SHIFT0: assert property ((shift_s == 2'h0)[*2] |-> // R14
        tx_enable_out_o == $past(tx_en_raw))
        else $error("transmit delay of zero steps not applied");
    AST_MGMT_READ_TURN: assert property ((mgmt_busy_o && m_read && m_bit >= MGMT_TA_BIT) // R5
        |=> !mgmt_data_io_oe_o)
        else $error("data line driven during read turnaround");

endmodule

`default_nettype wire

// ---- mii_port_pkg.sv ----
// constants and types shared by the per-port mii attachment
// assumes a 10 MHz system clock and a single synchronous reset domain
`default_nettype none

package mii_port_pkg;

    localparam int CLK_SYS_PERIOD_NS  = 100;

    // transmit output delay: four steps of one step each
    localparam int TX_SHIFT_STEPS     = 4;
    localparam int TX_SHIFT_STEP_NS   = 10;
    localparam int TX_SHIFT_STEP_RAW  = (TX_SHIFT_STEP_NS + CLK_SYS_PERIOD_NS - 1)
                                        / CLK_SYS_PERIOD_NS;
    localparam int TX_SHIFT_STEP_CYC  = (TX_SHIFT_STEP_RAW < 1) ? 1 : TX_SHIFT_STEP_RAW;

    // management clock around 700 kHz
    localparam int MGMT_CLK_PERIOD_NS = 1440;
    localparam int MGMT_HALF_RAW      = (MGMT_CLK_PERIOD_NS / 2) / CLK_SYS_PERIOD_NS;
    localparam int MGMT_HALF_CYC      = (MGMT_HALF_RAW < 1) ? 1 : MGMT_HALF_RAW;

    // management frame layout, bit index counted from the first bit sent
    localparam logic [5:0] MGMT_LAST_BIT = 6'h3F;
    localparam logic [5:0] MGMT_TA_BIT   = 6'h2E;
    localparam logic [5:0] MGMT_DATA_BIT = 6'h30;
    localparam logic [1:0] MGMT_SOF      = 2'h1;
    localparam logic [1:0] MGMT_OP_READ  = 2'h2;
    localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
    localparam logic [1:0] MGMT_TA_WRITE = 2'h2;

    localparam logic [4:0] PHY_ADDR_OFFSET_MASK = 5'h10;

    localparam int TX_FIFO_WIDTH = 8;
    localparam int TX_FIFO_DEPTH = 4;

    typedef enum logic [1:0] {TX_IDLE, TX_LO, TX_HI} tx_state_t;

endpackage

`default_nettype wire

// ---- tx_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
// assumes both sides run on the system clock
`default_nettype none

module tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output var  logic             in_ready_o,
    output var  logic [WIDTH-1:0] out_data_o,
    output var  logic             out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    always_comb begin
        push        = in_valid_i && in_ready_o;
        pop         = out_valid_o && out_ready_i;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
        end
        if (push && !pop) begin
            next_count = CW'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = CW'(count - 1'b1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end else begin
            wr_ptr      <= next_wr_ptr;
            rd_ptr      <= next_rd_ptr;
            count       <= next_count;
            in_ready_o  <= (next_count != CW'(DEPTH));
            out_valid_o <= (next_count != '0);
        end
    end

    // storage needs no reset; valid gates every read
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    assign out_data_o = mem[rd_ptr];

endmodule

`default_nettype wire

// ---- phy_model.sv ----
// behavioural phy for one mii port: receive nibble source and management slave
// assumes the bench resolves the shared management data line with a pull-up
`default_nettype none

module phy_model #(
    parameter logic [15:0] READ_VALUE = 16'hB4E1
) (
    input  wire logic       mgmt_clock_i,
    input  wire logic       mdio_i,
    input  wire logic       host_oe_i,
    output var  logic       mdio_oe_o,
    output var  logic       mdio_drv_o,
    output var  logic       rx_clk_o,
    output var  logic       rx_dv_o,
    output var  logic [3:0] rxd_o,
    output var  logic       rx_err_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [63:0] cap;
    int          rises;

    initial begin
        {rx_clk_o, rx_dv_o, rx_err_o, mdio_oe_o, mdio_drv_o} = 5'h00;
        rxd_o = 4'h0;
        cap = 64'h0;
        rises = 0;
    end

    always @(posedge host_oe_i) rises = 0;

    always @(posedge mgmt_clock_i) begin
        cap = {cap[62:0], mdio_i};
        rises = rises + 1;
        if (rises >= 64) mdio_oe_o = 1'b0;
    end

    // answer bits change on the falling clock, after the host let go
    always @(negedge mgmt_clock_i) begin
        mdio_oe_o = !host_oe_i && rises >= 48 && rises < 64;
        mdio_drv_o = (rises >= 48 && rises < 64) ? READ_VALUE[63-rises] : 1'b0;
    end

    // rx clock only runs inside send, with one edge after rx_dv_o drops, slow enough for a 10 MHz sampler
    task automatic send(input logic [19:0] nibs, input int n, input logic [4:0] errs);
        for (int i = 0; i < n; i++) begin
            rx_dv_o = 1'b1;
            rxd_o = nibs[4*i +: 4];
            rx_err_o = errs[i];
            #300 rx_clk_o = 1'b1;
            #300 rx_clk_o = 1'b0;
        end
        rx_dv_o = 1'b0;
        rxd_o = ~rxd_o;
        rx_err_o = 1'b0;
        #300 rx_clk_o = 1'b1;
        #300 rx_clk_o = 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- mii_phy_port_bench.sv ----
// self-checking bench for the mii port: config table, tx, rx, management
// assumes phy_model on the far side and a pulled-up management data line
`default_nettype none

module mii_phy_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rst_b = 0, link = 0, pol = 0, off = 0, nz = 0, enh = 0;
    logic        use_reg = 0, tx_valid = 0, tx_hold = 1, m_start = 0, m_write = 0;
    logic [1:0]  shift = 0, port = 0;
    logic [4:0]  preg = 0, m_reg = 0, addr;
    logic [7:0]  tx_data = 0, rx_byte;
    logic [15:0] m_wdata = 0, rdata;
    logic [3:0]  txd, rxd;
    logic        rx_clk, rx_dv, rx_err, p_oe, p_drv, mdc, m_do, m_oe, tx_en, tx_ready;
    logic        rx_valid, rx_berr, rx_end, rx_odd, up, enh_en, busy, done;
    wire         mdio_line = m_oe ? m_do : (p_oe ? p_drv : 1'b1);
    int          mismatches = 0, comparisons = 0, n, lows, ends = 0, lat[4];
    logic [8:0]  rxq[$];
    logic [7:0]  txb[4] = '{8'h5A, 8'hC3, 8'h17, 8'hE8};
    // off nz enh use port[2] reg[5] link pol | addr[5] up enh_en
    logic [19:0] rows[5] = '{20'h2810B, 20'hAC1CC, 20'h64086, 20'h9064C, 20'h30589};

    mii_phy_port #(.MGMT_HALF(4), .STEP_CYC(1)) i_mii_phy_port (
        .clk_sys_i(clk), .rst_b_i(rst_b), .link_mii_i(link), .link_input_polarity_cfg_i(pol),
        .phy_addr_offset_cfg_i(off), .phy_actual_offset_nz_i(nz), .enh_link_req_i(enh),
        .tx_shift_i(shift), .port_num_i(port), .use_addr_reg_i(use_reg),
        .phy_addr_reg_i(preg), .rx_clk_i(rx_clk), .rx_dv_i(rx_dv), .rxd_i(rxd),
        .rx_err_i(rx_err), .tx_enable_out_o(tx_en), .txd_o(txd), .tx_data_i(tx_data),
        .tx_valid_i(tx_valid), .tx_hold_i(tx_hold), .tx_ready_o(tx_ready),
        .rx_byte_o(rx_byte), .rx_byte_valid_o(rx_valid), .rx_byte_err_o(rx_berr),
        .rx_end_o(rx_end), .rx_odd_o(rx_odd), .link_up_o(up), .enh_link_en_o(enh_en),
        .phy_addr_o(addr), .mgmt_start_i(m_start), .mgmt_write_i(m_write),
        .mgmt_reg_i(m_reg), .mgmt_wdata_i(m_wdata), .mgmt_busy_o(busy),
        .mgmt_done_o(done), .mgmt_rdata_o(rdata), .mgmt_clock_out_o(mdc),
        .mgmt_data_io_o(m_do), .mgmt_data_io_oe_o(m_oe), .mgmt_data_io_i(mdio_line));

    phy_model i_phy_model (
        .mgmt_clock_i(mdc), .mdio_i(mdio_line), .host_oe_i(m_oe), .mdio_oe_o(p_oe),
        .mdio_drv_o(p_drv), .rx_clk_o(rx_clk), .rx_dv_o(rx_dv), .rxd_o(rxd),
        .rx_err_o(rx_err));

    always #50 clk = ~clk;

    always @(posedge clk) begin
        if (rx_valid === 1'b1) rxq.push_back({rx_berr, rx_byte});
        if (rx_end === 1'b1) ends++;
    end

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // valid stays up between pushes so it never toggles within one step
    task automatic push(input logic [7:0] b);
        logic ok;
        tx_data = b;
        tx_valid = 1'b1;
        do begin
            ok = tx_ready;
            tick(1);
        end while (!ok);
    endtask

    task automatic mgmt(input logic wr, input logic [4:0] r, input logic [15:0] wd);
        m_write = wr;
        m_reg = r;
        m_wdata = wd;
        m_start = 1'b1;
        tick(1);
        m_start = 1'b0;
        check(busy, 1, "mgmt busy");
        n = 0;
        lows = 0;
        while (done !== 1'b1 && n < 1000) begin
            lows += (mdc === 1'b0);
            tick(1);
            n++;
        end
        check(n > 500 && n < 520, 1, "mgmt length");
        check(lows > 0, 1, "mgmt clock toggled");
        tick(2);
        check(mdc, 1, "mgmt clock idle");
    endtask

    initial begin
        #1_000_000;
        mismatches++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end

    initial begin
        tick(12);
        check({mdc, m_oe, tx_en}, 3'h4, "reset outputs");
        rst_b = 1'b1;
        tick(2);
        $display("done: reset");
        for (int i = 0; i < 5; i++) begin
            {off, nz, enh, use_reg, port, preg, link, pol} = rows[i][19:7];
            tick(4);
            check({addr, up, enh_en}, rows[i][6:0], "config row");
        end
        $display("done: config table");
        for (int s = 0; s < 4; s++) begin
            shift = s[1:0];
            tx_hold = 1'b1;
            for (int b = 0; b < 4; b++) push(txb[b]);
            tx_valid = 1'b0;
            tick(1);
            check(tx_ready, 0, "buffer full");
            tx_data = 8'hFF;
            tx_valid = 1'b1;
            tick(3);
            tx_valid = 1'b0;
            tx_hold = 1'b0;
            n = 0;
            while (tx_en !== 1'b1 && n < 20) begin
                tick(1);
                n++;
            end
            lat[s] = n;
            check(n - lat[0], s, "tx delay steps");
            for (int k = 0; k < 8; k++) begin
                check(txd, txb[k/2][4*(k%2) +: 4], "tx nibble");
                tick(1);
            end
            check(tx_en, 0, "tx frame end");
        end
        check(lat[3] - lat[0], 3, "tx delay steps");
        $display("done: transmit");
        i_phy_model.send(20'h7A53C, 5, 5'h04);
        tick(4);
        check(rxq.size(), 2, "rx byte count");
        check(rxq[0], 9'h03C, "rx byte 0");
        check(rxq[1], 9'h1A5, "rx byte 1 with error");
        check({rx_odd, ends[1:0]}, 3'h5, "rx odd end");
        $display("done: receive");
        mgmt(1'b0, 5'h01, 16'h0000);
        check(rdata, 16'hB4E1, "mgmt read data");
        check(i_phy_model.cap[31:18], {4'h6, 5'h02, 5'h01}, "read header");
        mgmt(1'b1, 5'h04, 16'h3C96);
        check(i_phy_model.cap[31:0], {4'h5, 5'h02, 5'h04, 2'h2, 16'h3C96}, "write");
        check(i_phy_model.cap[63:32], 32'hFFFFFFFF, "preamble");
        $display("done: management");
        end_of_test();
    end
endmodule

`default_nettype wire
